// file: rtl/ecac_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 200 MHz clock and a 16-bit holding-register port
//
// Overview of operation
// - bit 15 set enables running count reporting
// - bit 0 selects auto-reset or latching termination
// - auto-reset: clear counter, pulse alarm about 100ms
// - latching: hold at limit, alarm until reset
// - reading running count may cost events
// - cutoff 0 to 10000 tenths Hz, low ranges
// - low ranges report below-cutoff frequency as zero
// - clear field: 01 first, 10 second, 11 both
// - clear register keeps nothing, always reads zero
// - high, low, deadband held as 16-bit unsigned
// - low limit and deadband ignored for counters
// - alarm control bit 2 selects output sense
// - alarm control bit 1 enables high alarm
// - alarm control bit 0 enables low alarm
// - auto-reset counter forces high alarm enabled
// - counter alarm output always non-failsafe
// - trigger edge bit: 0 rising, 1 falling
// - debounce after event: count times 5 ms
`ifndef ECAC_REGS_SVH
`define ECAC_REGS_SVH

`define ECAC_ADDR_DEBOUNCE 16'h000b
`define ECAC_ADDR_EDGE 16'h000c
`define ECAC_ADDR_ACQ_TERM 16'h000d
`define ECAC_ADDR_CUTOFF 16'h000e
`define ECAC_ADDR_CLEAR 16'h000f
`define ECAC_ADDR_HIGH 16'h0010
`define ECAC_ADDR_LOW 16'h0011
`define ECAC_ADDR_DEADBAND 16'h0012
`define ECAC_ADDR_ALARM_CTRL 16'h0013

`define ECAC_BIT_ACQUIRE 15
`define ECAC_BIT_LATCH 0
`define ECAC_BIT_FALL_EDGE 0
`define ECAC_BIT_NONFAILSAFE 2
`define ECAC_BIT_HI_EN 1
`define ECAC_BIT_LO_EN 0
`define ECAC_DEB_W 10
`define ECAC_CLR_W 2

`define ECAC_RST_DEBOUNCE 10'h000
`define ECAC_RST_CUTOFF 16'h0005
`define ECAC_RST_HIGH 16'hffff
`define ECAC_RST_LOW 16'h0001
`define ECAC_RST_DEADBAND 16'h01f4
`define ECAC_CUTOFF_MAX 16'h2710

`define ECAC_CLK_MHZ 200
`define ECAC_ALARM_PULSE_MS 100
`define ECAC_DEB_STEP_MS 5
`define ECAC_ALARM_PULSE_CYC (`ECAC_ALARM_PULSE_MS * `ECAC_CLK_MHZ * 1000)
`define ECAC_DEB_STEP_CYC (`ECAC_DEB_STEP_MS * `ECAC_CLK_MHZ * 1000)

`endif

// file: rtl/ecac_pkg.sv
// types shared by the event counter and alarm logic
// assumes ecac_regs.svh for the field widths
`include "ecac_regs.svh"
package ecac_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ecac_req_t;
  typedef struct packed {
    logic nonfailsafe;
    logic hi_en;
    logic lo_en;
  } ecac_alarm_ctrl_t;
  typedef enum logic {ECAC_DEB_IDLE, ECAC_DEB_HOLD} ecac_deb_state_t;
endpackage

// file: rtl/ecac_event_counter.sv
// one event counter with edge select, debounce and limit termination
// assumes a synchronised input level on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "ecac_regs.svh"
module ecac_event_counter #(
  parameter int CNT_W = 16,
  parameter int STEP_CYC = `ECAC_DEB_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_level,
  input wire logic i_fall_edge,
  input wire logic i_latch,
  input wire logic i_clear,
  input wire logic [`ECAC_DEB_W-1:0] i_deb_mult,
  input wire logic [CNT_W-1:0] i_high,
  output logic [CNT_W-1:0] o_count,
  output logic o_hit,
  output logic o_latched
);
  import ecac_pkg::*;
  localparam int SW = $clog2(STEP_CYC + 1);
  if (STEP_CYC < 1 || CNT_W < 1) begin : g_chk
    $error("ecac_event_counter: bad parameters");
  end
  logic prev_q;
  logic edge_seen;
  logic accept;
  ecac_deb_state_t deb_q;
  logic [SW-1:0] step_q;
  logic [`ECAC_DEB_W-1:0] mult_q;
  logic [CNT_W-1:0] base;
  logic [CNT_W-1:0] next_cnt;
  logic latched_base;
  logic [CNT_W-1:0] count_d;
  logic latched_d;
  logic hit_d;

  always_ff @(posedge i_clk) begin
    prev_q <= i_rst ? 1'b0 : i_level;
  end
  // rising edge unless falling selected
  assign edge_seen = i_fall_edge ? (prev_q & ~i_level) : (~prev_q & i_level);
  assign accept = edge_seen && (deb_q == ECAC_DEB_IDLE);

  // hold-off of mult x 5 ms after each logged event
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      deb_q <= ECAC_DEB_IDLE;
      step_q <= '0;
      mult_q <= '0;
    end else begin
      case (deb_q)
        ECAC_DEB_IDLE: begin
          if (accept && i_deb_mult != '0) begin
            deb_q <= ECAC_DEB_HOLD;
            mult_q <= i_deb_mult;
            step_q <= SW'(STEP_CYC - 1);
          end
        end
        ECAC_DEB_HOLD: begin
          if (step_q != '0) begin
            step_q <= step_q - 1'b1;
          end else if (mult_q <= `ECAC_DEB_W'(1)) begin
            deb_q <= ECAC_DEB_IDLE;
          end else begin
            mult_q <= mult_q - 1'b1;
            step_q <= SW'(STEP_CYC - 1);
          end
        end
        default: deb_q <= ECAC_DEB_IDLE;
      endcase
    end
  end

  // a clear and an event in one cycle: the event survives as a count of one
  always_comb begin
    base = i_clear ? '0 : o_count;
    latched_base = i_clear ? 1'b0 : o_latched;
    next_cnt = base + 1'b1;
    count_d = base;
    latched_d = latched_base;
    hit_d = 1'b0;
    if (accept && !latched_base) begin
      count_d = next_cnt;
      if (next_cnt >= i_high) begin
        if (i_latch) begin
          count_d = i_high;
          latched_d = 1'b1;
        end else begin
          count_d = '0;
          hit_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_count <= '0;
      o_latched <= 1'b0;
      o_hit <= 1'b0;
    end else begin
      o_count <= count_d;
      o_latched <= latched_d;
      o_hit <= hit_d;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ecac_alarm.sv
// first channel alarm output: counter pulse/latch or frequency limits
// assumes limits in Hz and measured frequency in tenths of Hz
`timescale 1ns/1ps
`default_nettype none
`include "ecac_regs.svh"
module ecac_alarm #(
  parameter int PULSE_CYC = `ECAC_ALARM_PULSE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_is_counter,
  input wire logic i_latch,
  input wire ecac_pkg::ecac_alarm_ctrl_t i_ctrl,
  input wire logic i_hit,
  input wire logic i_latched,
  input wire logic [15:0] i_freq,
  input wire logic [15:0] i_high,
  input wire logic [15:0] i_low,
  input wire logic [15:0] i_deadband,
  output logic o_alarm_pin,
  output logic o_alarm_led
);
  import ecac_pkg::*;
  localparam int PW = $clog2(PULSE_CYC + 1);
  if (PULSE_CYC < 1) begin : g_chk
    $error("ecac_alarm: PULSE_CYC must be at least 1");
  end
  logic [PW-1:0] pulse_q;
  logic hi_q;
  logic lo_q;
  logic [20:0] fh;
  logic [20:0] hi_thr;
  logic [20:0] lo_thr;
  logic [20:0] db;
  logic hi_en;
  logic active;
  logic nonfs;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_q <= '0;
    end else if (i_hit) begin
      pulse_q <= PW'(PULSE_CYC);
    end else if (pulse_q != '0) begin
      pulse_q <= pulse_q - 1'b1;
    end
  end

  assign fh = 21'(i_freq);
  assign hi_thr = 21'(i_high) * 21'd10;
  assign lo_thr = 21'(i_low) * 21'd10;
  assign db = 21'(i_deadband) * 21'd10;

  // deadband gives hysteresis so a noisy input does not chatter the relay
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      if (fh >= hi_thr) begin
        hi_q <= 1'b1;
      end else if (fh + db < hi_thr) begin
        hi_q <= 1'b0;
      end
      if (fh < lo_thr) begin
        lo_q <= 1'b1;
      end else if (fh >= lo_thr + db) begin
        lo_q <= 1'b0;
      end
    end
  end

  always_comb begin
    if (i_is_counter) begin
      hi_en = i_ctrl.hi_en | ~i_latch;
      active = hi_en & (i_latch ? i_latched : (pulse_q != '0));
      nonfs = 1'b1;
    end else begin
      // low limit only counts outside counter mode
      active = (i_ctrl.hi_en & hi_q) | (i_ctrl.lo_en & lo_q);
      hi_en = i_ctrl.hi_en;
      nonfs = i_ctrl.nonfailsafe;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_alarm_pin <= 1'b0;
      o_alarm_led <= 1'b0;
    end else begin
      o_alarm_pin <= nonfs ? active : ~active;
      o_alarm_led <= active;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ecac_top.sv
// holding registers, input sync, two event counters, cutoff and alarm
// assumes a network decoder presenting one-cycle read/write strobes
`timescale 1ns/1ps
`default_nettype none
`include "ecac_regs.svh"
module ecac_top #(
  parameter int PULSE_CYC = `ECAC_ALARM_PULSE_CYC,
  parameter int STEP_CYC = `ECAC_DEB_STEP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ecac_pkg::ecac_req_t i_req,
  output logic [15:0] o_rdata,
  output logic o_rd_ack,
  input wire logic [1:0] i_pin_in,
  input wire logic [1:0] i_is_counter,
  input wire logic [1:0] i_low_range,
  input wire logic [15:0] i_ch0_freq,
  input wire logic [15:0] i_ch1_freq,
  input wire logic [15:0] i_ch1_high_limit,
  output logic [15:0] o_ch0_freq,
  output logic [15:0] o_ch1_freq,
  output logic [15:0] o_ch0_count,
  output logic [15:0] o_ch1_count,
  output logic o_count_valid,
  output logic o_ch1_limit_hit,
  output logic o_alarm_pin,
  output logic o_alarm_led
);
  import ecac_pkg::*;
  if (PULSE_CYC < 1 || STEP_CYC < 1) begin : g_chk
    $error("ecac_top: timing parameters must be at least 1");
  end

  logic [`ECAC_DEB_W-1:0] deb_mult_q;
  logic fall_edge_q;
  logic acquire_q;
  logic latch_q;
  logic [15:0] cutoff_q;
  logic [15:0] high_q;
  logic [15:0] low_q;
  logic [15:0] deadband_q;
  ecac_alarm_ctrl_t alarm_ctrl_q;
  logic [`ECAC_CLR_W-1:0] clear_d;
  logic [15:0] rdata_d;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] clear_ch;
  logic [1:0] hit;
  logic [1:0] latched;
  logic [15:0] count [2];
  logic [15:0] high_ch [2];
  logic [15:0] freq_in [2];
  logic [15:0] freq_out [2];
  logic wr_hit;

  assign wr_hit = i_req.wr;

  // configuration writes; each register stored in its own process
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      deb_mult_q <= `ECAC_RST_DEBOUNCE;
    end else if (wr_hit && i_req.addr == `ECAC_ADDR_DEBOUNCE) begin
      deb_mult_q <= i_req.wdata[`ECAC_DEB_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fall_edge_q <= 1'b0;
    end else if (wr_hit && i_req.addr == `ECAC_ADDR_EDGE) begin
      fall_edge_q <= i_req.wdata[`ECAC_BIT_FALL_EDGE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acquire_q <= 1'b0;
      latch_q <= 1'b0;
    end else if (wr_hit && i_req.addr == `ECAC_ADDR_ACQ_TERM) begin
      acquire_q <= i_req.wdata[`ECAC_BIT_ACQUIRE];
      latch_q <= i_req.wdata[`ECAC_BIT_LATCH];
    end
  end

  // out-of-range cutoff saturates rather than wrapping to a tiny value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cutoff_q <= `ECAC_RST_CUTOFF;
    end else if (wr_hit && i_req.addr == `ECAC_ADDR_CUTOFF) begin
      if (i_req.wdata > `ECAC_CUTOFF_MAX) begin
        cutoff_q <= `ECAC_CUTOFF_MAX;
      end else begin
        cutoff_q <= i_req.wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      high_q <= `ECAC_RST_HIGH;
    end else if (wr_hit && i_req.addr == `ECAC_ADDR_HIGH) begin
      high_q <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      low_q <= `ECAC_RST_LOW;
    end else if (wr_hit && i_req.addr == `ECAC_ADDR_LOW) begin
      low_q <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      deadband_q <= `ECAC_RST_DEADBAND;
    end else if (wr_hit && i_req.addr == `ECAC_ADDR_DEADBAND) begin
      deadband_q <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alarm_ctrl_q <= '0;
    end else if (wr_hit && i_req.addr == `ECAC_ADDR_ALARM_CTRL) begin
      alarm_ctrl_q.nonfailsafe <= i_req.wdata[`ECAC_BIT_NONFAILSAFE];
      alarm_ctrl_q.hi_en <= i_req.wdata[`ECAC_BIT_HI_EN];
      alarm_ctrl_q.lo_en <= i_req.wdata[`ECAC_BIT_LO_EN];
    end
  end

  // the clear field acts as a one-cycle command and is never stored
  always_comb begin
    if (wr_hit && i_req.addr == `ECAC_ADDR_CLEAR) begin
      clear_d = i_req.wdata[`ECAC_CLR_W-1:0];
    end else begin
      clear_d = '0;
    end
  end
  assign clear_ch = clear_d; // bit 0 first, bit 1 second

  // read decode; unmapped and clear addresses answer zero
  always_comb begin
    rdata_d = '0;
    if (i_req.addr == `ECAC_ADDR_DEBOUNCE) begin
      rdata_d = 16'(deb_mult_q);
    end else if (i_req.addr == `ECAC_ADDR_EDGE) begin
      rdata_d[`ECAC_BIT_FALL_EDGE] = fall_edge_q;
    end else if (i_req.addr == `ECAC_ADDR_ACQ_TERM) begin
      rdata_d[`ECAC_BIT_ACQUIRE] = acquire_q;
      rdata_d[`ECAC_BIT_LATCH] = latch_q;
    end else if (i_req.addr == `ECAC_ADDR_CUTOFF) begin
      rdata_d = cutoff_q;
    end else if (i_req.addr == `ECAC_ADDR_CLEAR) begin
      rdata_d = '0;
    end else if (i_req.addr == `ECAC_ADDR_HIGH) begin
      rdata_d = high_q;
    end else if (i_req.addr == `ECAC_ADDR_LOW) begin
      rdata_d = low_q;
    end else if (i_req.addr == `ECAC_ADDR_DEADBAND) begin
      rdata_d = deadband_q;
    end else if (i_req.addr == `ECAC_ADDR_ALARM_CTRL) begin
      rdata_d[`ECAC_BIT_NONFAILSAFE] = alarm_ctrl_q.nonfailsafe;
      rdata_d[`ECAC_BIT_HI_EN] = alarm_ctrl_q.hi_en;
      rdata_d[`ECAC_BIT_LO_EN] = alarm_ctrl_q.lo_en;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
      o_rd_ack <= 1'b0;
    end else begin
      o_rd_ack <= i_req.rd;
      if (i_req.rd) begin
        o_rdata <= rdata_d;
      end
    end
  end

  // pins are asynchronous: two flops before the edge detector
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= i_pin_in;
      sync2_q <= sync1_q;
    end
  end

  assign high_ch[0] = high_q;
  assign high_ch[1] = i_ch1_high_limit;
  assign freq_in[0] = i_ch0_freq;
  assign freq_in[1] = i_ch1_freq;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    ecac_event_counter #(
      .CNT_W(16),
      .STEP_CYC(STEP_CYC)
    ) u_cnt (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_level(sync2_q[c] & i_is_counter[c]),
      .i_fall_edge(fall_edge_q),
      .i_latch(latch_q),
      .i_clear(clear_ch[c]),
      .i_deb_mult(deb_mult_q),
      .i_high(high_ch[c]),
      .o_count(count[c]),
      .o_hit(hit[c]),
      .o_latched(latched[c])
    );
    // below-cutoff frequencies read as zero in the low ranges only
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        freq_out[c] <= '0;
      end else if (i_low_range[c] && freq_in[c] < cutoff_q) begin
        freq_out[c] <= '0;
      end else begin
        freq_out[c] <= freq_in[c];
      end
    end
  end

  assign o_ch0_freq = freq_out[0];
  assign o_ch1_freq = freq_out[1];

  // running count is copied out only while acquire is on; the copy never
  // stalls counting, so the missed-event hazard lies with the network poll
  always_ff @(posedge i_clk) begin
    if (i_rst || !acquire_q) begin
      o_ch0_count <= '0;
      o_ch1_count <= '0;
      o_count_valid <= 1'b0;
    end else begin
      o_ch0_count <= count[0];
      o_ch1_count <= count[1];
      o_count_valid <= 1'b1;
    end
  end

  assign o_ch1_limit_hit = hit[1];

  ecac_alarm #(
    .PULSE_CYC(PULSE_CYC)
  ) u_alarm (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_is_counter(i_is_counter[0]),
    .i_latch(latch_q),
    .i_ctrl(alarm_ctrl_q),
    .i_hit(hit[0]),
    .i_latched(latched[0]),
    .i_freq(freq_out[0]),
    .i_high(high_q),
    .i_low(low_q),
    .i_deadband(deadband_q),
    .o_alarm_pin(o_alarm_pin),
    .o_alarm_led(o_alarm_led)
  );
endmodule
`default_nettype wire

// file: tb/ecac_top_chk.sv
// checker on the top level of the event counter and alarm block
// assumes ch0 runs as a counter and its limit is never lowered under a count
`timescale 1ns/1ps
`default_nettype none
module ecac_top_chk
  import ecac_pkg::*;
#(
  parameter int PULSE_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ecac_pkg::ecac_req_t i_req,
  input wire logic [1:0] i_is_counter,
  input wire logic [1:0] i_low_range,
  input wire logic [15:0] i_ch0_freq,
  input wire logic [15:0] i_ch1_freq,
  input wire logic [15:0] o_rdata,
  input wire logic o_rd_ack,
  input wire logic [15:0] o_ch0_freq,
  input wire logic [15:0] o_ch1_freq,
  input wire logic [15:0] o_ch0_count,
  input wire logic [15:0] o_ch1_count,
  input wire logic o_count_valid,
  input wire logic o_alarm_pin,
  input wire logic o_alarm_led
);
  logic [15:0] cut_q, hi_q;
  logic latch_q;
  logic [2:0] wr_hist_q;
  logic [31:0] led_cnt_q;
  logic wr_clr, wr_acq;
  assign wr_clr = i_req.wr && i_req.addr == 16'h000f;
  assign wr_acq = i_req.wr && i_req.addr == 16'h000d;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // shadow copies of settings, since the checker sees only the ports
  always_ff @(posedge i_clk) begin
    if (i_rst) cut_q <= 16'h0005;
    else if (i_req.wr && i_req.addr == 16'h000e)
      cut_q <= (i_req.wdata > 16'h2710) ? 16'h2710 : i_req.wdata;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) hi_q <= 16'hffff;
    else if (i_req.wr && i_req.addr == 16'h0010) hi_q <= i_req.wdata;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) latch_q <= 1'b0;
    else if (wr_acq) latch_q <= i_req.wdata[0];
  end
  // any recent write may legally move the alarm, so holds skip those cycles
  always_ff @(posedge i_clk) begin
    wr_hist_q <= i_rst ? 3'h0 : {wr_hist_q[1:0], i_req.wr};
  end
  always_ff @(posedge i_clk) begin
    led_cnt_q <= (i_rst || !o_alarm_led) ? 32'h0 : led_cnt_q + 32'h1;
  end
  clr_read_zero_a: assert property (
    i_req.rd && i_req.addr == 16'h000f |=> o_rd_ack && o_rdata == 16'h0)
    else $error("clear register read not zero");
  acq_on_a: assert property (
    wr_acq && i_req.wdata[15] |-> ##[1:3] o_count_valid)
    else $error("count reporting not enabled");
  acq_off_a: assert property (
    wr_acq && !i_req.wdata[15] |-> ##[1:3] !o_count_valid)
    else $error("count reporting not disabled");
  no_acq_zero_a: assert property (
    !o_count_valid |-> o_ch0_count == 16'h0 && o_ch1_count == 16'h0)
    else $error("count shown while not acquiring");
  cut_zero0_a: assert property (
    i_low_range[0] && i_ch0_freq < cut_q |=> o_ch0_freq == 16'h0)
    else $error("ch0 below cutoff not zero");
  cut_zero1_a: assert property (
    i_low_range[1] && i_ch1_freq < cut_q |=> o_ch1_freq == 16'h0)
    else $error("ch1 below cutoff not zero");
  pass_freq_a: assert property (
    !i_low_range[0] |=> o_ch0_freq == $past(i_ch0_freq))
    else $error("ch0 frequency altered outside low range");
  clr_ch0_a: assert property (
    wr_clr && i_req.wdata[0] |-> ##[1:3] o_ch0_count == 16'h0)
    else $error("ch0 counter not cleared");
  clr_ch1_a: assert property (
    wr_clr && i_req.wdata[1] |-> ##[1:3] o_ch1_count == 16'h0)
    else $error("ch1 counter not cleared");
  pulse_len_a: assert property (
    i_is_counter[0] && !latch_q |-> led_cnt_q <= PULSE_CYC + 1)
    else $error("auto-reset alarm pulse too long");
  latch_hold_a: assert property (
    latch_q && i_is_counter[0] && o_alarm_led && !i_req.wr &&
    wr_hist_q == 3'h0 |=> o_alarm_led)
    else $error("latched alarm dropped without clear");
  latch_cap_a: assert property (
    latch_q && i_is_counter[0] |-> o_ch0_count <= hi_q)
    else $error("latched count passed the limit");
  sense_a: assert property (
    i_is_counter[0] && $past(i_is_counter[0]) |-> o_alarm_pin == o_alarm_led)
    else $error("counter alarm not non-failsafe");
endmodule
bind ecac_top ecac_top_chk #(.PULSE_CYC(PULSE_CYC)) u_ecac_top_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_is_counter(i_is_counter),
  .i_low_range(i_low_range), .i_ch0_freq(i_ch0_freq),
  .i_ch1_freq(i_ch1_freq), .o_rdata(o_rdata), .o_rd_ack(o_rd_ack),
  .o_ch0_freq(o_ch0_freq), .o_ch1_freq(o_ch1_freq),
  .o_ch0_count(o_ch0_count), .o_ch1_count(o_ch1_count),
  .o_count_valid(o_count_valid), .o_alarm_pin(o_alarm_pin),
  .o_alarm_led(o_alarm_led));
`default_nettype wire

// file: tb/ecac_host_model.sv
// host network master issuing holding-register reads and writes
// assumes one-cycle strobes and a read acknowledge within three cycles
`timescale 1ns/1ps
`default_nettype none
module ecac_host_model
  import ecac_pkg::*;
(
  input wire logic i_clk,
  output var ecac_pkg::ecac_req_t o_req,
  input wire logic [15:0] i_rdata,
  input wire logic i_rd_ack
);
  initial o_req = '0;
  // idle address and data carry the inverse so a stale bus cannot match
  task automatic write_reg(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic read_reg(input logic [15:0] a, output logic [15:0] d);
    logic got;
    got = 1'b0;
    d = 16'hxxxx;
    @(negedge i_clk);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
    @(negedge i_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    repeat (3) begin
      if (!got && i_rd_ack === 1'b1) begin
        d = i_rdata;
        got = 1'b1;
      end else if (!got) begin
        @(negedge i_clk);
      end
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the event counter and alarm top level
// assumes shortened alarm pulse and debounce step counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check16(16'(g), 16'(e))
module tb;
  import ecac_pkg::*;
  localparam int PULSE = 20;
  localparam int STEP = 4;
  localparam logic [127:0] RA = {16'h0020, 16'h0013, 16'h0012, 16'h0011,
    16'h0010, 16'h000f, 16'h000e, 16'h000d};
  localparam logic [127:0] RV = {16'h0, 16'h0, 16'h01f4, 16'h0001,
    16'hffff, 16'h0, 16'h0005, 16'h0};
  localparam logic [95:0] WA = {16'h000e, 16'h000d, 16'h0013, 16'h0012,
    16'h0011, 16'h0010};
  localparam logic [95:0] WV = {16'h2710, 16'h8001, 16'h0005, 16'ha5a5,
    16'hfedc, 16'h1234};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] pin_in = 2'b00;
  logic [1:0] is_ctr = 2'b11;
  logic [1:0] low_rng = 2'b00;
  logic [15:0] f0 = 16'h0, f1 = 16'h0, hi1 = 16'hffff;
  ecac_req_t req;
  logic [15:0] rdata, ch0_f, ch1_f, ch0_cnt, ch1_cnt;
  logic rd_ack, valid, lim_hit, alarm_pin, alarm_led;
  int mismatches = 0;
  int num_checks = 0;
  int c0, c1;
  int hit_cnt = 0;
  ecac_top #(.PULSE_CYC(PULSE), .STEP_CYC(STEP)) u_ecac_top (
    .i_clk(clk), .i_rst(rst), .i_req(req), .o_rdata(rdata),
    .o_rd_ack(rd_ack), .i_pin_in(pin_in), .i_is_counter(is_ctr),
    .i_low_range(low_rng), .i_ch0_freq(f0), .i_ch1_freq(f1),
    .i_ch1_high_limit(hi1), .o_ch0_freq(ch0_f), .o_ch1_freq(ch1_f),
    .o_ch0_count(ch0_cnt), .o_ch1_count(ch1_cnt), .o_count_valid(valid),
    .o_ch1_limit_hit(lim_hit), .o_alarm_pin(alarm_pin),
    .o_alarm_led(alarm_led));
  ecac_host_model u_ecac_host_model (.i_clk(clk), .o_req(req),
    .i_rdata(rdata), .i_rd_ack(rd_ack));
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_ecac_host_model.write_reg(a, d);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_ecac_host_model.read_reg(a, d);
    `CHK(d, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // a pulse leaves room for sync, count and output register to settle
  task automatic pulse(input logic [1:0] m);
    @(negedge clk);
    pin_in = m;
    wait_n(4);
    pin_in = 2'b00;
    wait_n(6);
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  // the second channel hit flag stands one cycle, so one falling edge sees it
  always @(negedge clk) begin
    if (lim_hit) begin
      hit_cnt++;
    end
  end
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    wait_n(5);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_chk(RA[16*i +: 16], RV[16*i +: 16]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(WA[16*i +: 16], WV[16*i +: 16]);
      rd_chk(WA[16*i +: 16], WV[16*i +: 16]);
    end
    wr(16'h000e, 16'hffff);
    rd_chk(16'h000e, 16'h2710);
    wr(16'h000f, 16'h0003);
    rd_chk(16'h000f, 16'h0);
    wr(16'h000e, 16'h0064);
    low_rng = 2'b11;
    for (int i = 0; i < 2; i++) begin
      f0 = 16'h0063 + 16'(i);
      f1 = f0;
      wait_n(3);
      `CHK(ch0_f, i ? f0 : 16'h0);
      `CHK(ch1_f, i ? f1 : 16'h0);
    end
    low_rng = 2'b00;
    f0 = 16'h0005;
    wait_n(3);
    `CHK(ch0_f, 16'h0005);
    wr(16'h0013, 16'h0001);
    wr(16'h000d, 16'h8000);
    wr(16'h0010, 16'h0003);
    wr(16'h000f, 16'h0003);
    pulse(2'b11);
    pulse(2'b11);
    `CHK(ch0_cnt, 2);
    `CHK(alarm_led, 0);
    pulse(2'b01);
    `CHK(ch0_cnt, 0);
    `CHK(alarm_led, 1);
    `CHK(alarm_pin, 1);
    wait_n(10);
    `CHK(alarm_led, 1);
    wait_n(15);
    `CHK(alarm_led, 0);
    wr(16'h000d, 16'h0000);
    pulse(2'b01);
    `CHK(ch0_cnt, 0);
    `CHK(valid, 0);
    wr(16'h000d, 16'h8000);
    wait_n(3);
    `CHK(ch0_cnt, 1);
    wr(16'h0010, 16'hffff);
    c0 = 1;
    c1 = 2;
    for (int k = 0; k < 4; k++) begin
      pulse(2'b11);
      c0++;
      c1++;
      wr(16'h000f, 16'(k));
      wait_n(3);
      if (k[0]) c0 = 0;
      if (k[1]) c1 = 0;
      `CHK(ch0_cnt, c0);
      `CHK(ch1_cnt, c1);
    end
    wr(16'h000c, 16'h0001);
    @(negedge clk);
    pin_in = 2'b01;
    wait_n(8);
    `CHK(ch0_cnt, 0);
    pin_in = 2'b00;
    wait_n(8);
    `CHK(ch0_cnt, 1);
    wr(16'h000c, 16'h0000);
    wr(16'h000b, 16'h0003);
    wr(16'h000f, 16'h0003);
    pulse(2'b01);
    pulse(2'b01);
    `CHK(ch0_cnt, 1);
    wait_n(10);
    pulse(2'b01);
    `CHK(ch0_cnt, 2);
    wr(16'h000b, 16'h0000);
    wr(16'h0013, 16'h0002);
    wr(16'h000d, 16'h8001);
    wr(16'h0010, 16'h0002);
    wr(16'h000f, 16'h0003);
    repeat (3) pulse(2'b01);
    `CHK(ch0_cnt, 2);
    wait_n(30);
    `CHK(alarm_led, 1);
    wr(16'h000f, 16'h0001);
    wait_n(3);
    `CHK(ch0_cnt, 0);
    `CHK(alarm_led, 0);
    is_ctr = 2'b10;
    wr(16'h000d, 16'h0000);
    wr(16'h0013, 16'h0000);
    wait_n(3);
    `CHK(alarm_pin, 1);
    wr(16'h0013, 16'h0004);
    wait_n(3);
    `CHK(alarm_pin, 0);
    wr(16'h0010, 16'h000a);
    f0 = 16'h00c8;
    wr(16'h0013, 16'h0006);
    wait_n(3);
    `CHK(alarm_pin, 1);
    wr(16'h0013, 16'h0004);
    wait_n(3);
    `CHK(alarm_pin, 0);
    wr(16'h0013, 16'h0005);
    wait_n(3);
    `CHK(alarm_pin, 1);
    hi1 = 16'h0001;
    pulse(2'b10);
    `CHK(hit_cnt, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
